// ===== hdl/lotg_pkg.sv
package lotg_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] LDO_CTRL_OFS    = 8'h00;
   localparam logic [7:0] LDO_STAT_OFS    = 8'h04;
   localparam logic [7:0] LDO_VSEL_OFS    = 8'h08;
   localparam logic [7:0] BUCK_VSEL_OFS   = 8'h0C;
   localparam logic [7:0] BOOST_VSEL_OFS  = 8'h10;
   localparam logic [7:0] SW_CTRL_OFS     = 8'h14;
   localparam logic [7:0] SW_STAT_OFS     = 8'h18;
   localparam logic [7:0] IRQ_STAT_OFS    = 8'h1C;
   localparam logic [7:0] IRQ_MASK_OFS    = 8'h20;
   localparam logic [7:0] VOUT_QUERY_OFS  = 8'h24;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int LDO_EN_POS    = 0;
   localparam int LDO_DIS_POS   = 4;
   localparam int LDO_FIE_POS   = 8;
   localparam int SW_VIN5_EN    = 0;
   localparam int SW_CHARGER_INPUT_EN   = 1;
   localparam int SW_VIN5_FIE   = 2;
   localparam int SW_CHARGER_INPUT_FIE  = 3;
   localparam int IRQ_VIN5_POS  = 4;
   localparam int IRQ_CHARGER_INPUT_POS = 5;
   localparam int IRQ_WIDTH     = 6;
   localparam int NUM_LDO       = 4;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [11:0] LDO_CTRL_RST   = 12'h000;
   localparam logic [23:0] LDO_VSEL_RST   = 24'h000000;
   localparam logic [17:0] BUCK_VSEL_RST  = 18'h00000;
   localparam logic [7:0]  BOOST_VSEL_RST = 8'h00;
   localparam logic [3:0]  SW_CTRL_RST    = 4'h0;

   // ----------------------------------------------------------------
   // timing: over-current hold-off
   // ----------------------------------------------------------------
   localparam longint CLK_HZ       = 25000000;
   localparam longint OC_TIME_MS   = 256;
   localparam longint OC_CYCLES_L  = (CLK_HZ * OC_TIME_MS) / 1000;
   localparam int     OC_CYCLES    = int'(OC_CYCLES_L);
   localparam int     OC_CNT_W     = 23;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   // first member is the top bits: enable sits in [3:0], fault enable in [11:8]
   typedef struct packed {
      logic [3:0] fault_irq_enable;
      logic [3:0] discharge;
      logic [3:0] enable;
   } lotg_ldo_ctrl_t;

   // vin5 enable lands in bit 0, charger_input fault enable in bit 3
   typedef struct packed {
      logic charger_input_switch_fault_irq_enable;
      logic vin5_switch_fault_irq_enable;
      logic charger_input_switch_enable;
      logic vin5_switch_enable;
   } lotg_sw_ctrl_t;

endpackage : lotg_pkg

// ===== hdl/lotg_oc_timer.sv
module lotg_oc_timer #(
   parameter int CYCLES = lotg_pkg::OC_CYCLES
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic over_limit,
   output logic      fire
);

   logic [lotg_pkg::OC_CNT_W-1:0] count_reg;

   // ----------------------------------------------------------------
   // persistence counter
   // ----------------------------------------------------------------
   // restarts on any dip below the limit; fire pulses once per episode
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= '0;
      end else if (!over_limit) begin
         count_reg <= '0;
      end else if (count_reg < lotg_pkg::OC_CNT_W'(CYCLES)) begin
         count_reg <= count_reg + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fire <= 1'b0;
      end else begin
         fire <= over_limit && (count_reg == lotg_pkg::OC_CNT_W'(CYCLES - 1));
      end
   end

   a_fire_after_count: assert property (@(posedge clk) disable iff (!reset_n)
      fire |-> $past(over_limit))
      else $error("over-current fire without over-limit");

   a_count_clear: assert property (@(posedge clk) disable iff (!reset_n)
      !over_limit |=> count_reg == '0)
      else $error("over-current count kept after limit dropped");

endmodule : lotg_oc_timer

// ===== hdl/lotg_sync2.sv
module lotg_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_reg;

   // first stage read only by the second
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule : lotg_sync2

// ===== hdl/lotg_ctrl.sv
// Notes on behaviour
// - each ldo has own enable bit
// - power-good reads 0 below 11% threshold
// - fault_irq_enable gates ldo regulation-loss interrupt
// - discharge path on when enabled and off
// - buck code: range base plus step
// - ldo code uses same six-bit map
// - boost code eight bits, capped 41.4 V
// - vin5 switch follows its enable bit
// - vin5 over-current 256 ms forces off
// - vin5 reclose needs 0 to 1 write
// - vin5 over-current raises interrupt when enabled
// - charger_input switch only while vin5 off
// - charger_input over-current 256 ms forces off
// - charger_input reclose needs 0 to 1 write
// - charger_input above 6 V forces switch off
// - charger_input over-current raises interrupt when enabled
//
// Design decisions made here: the placing of the registers and the APB slave port.
module lotg_ctrl (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [3:0]  ldo_below_threshold,
   input  wire logic        vin5_over_limit,
   input  wire logic        charger_input_over_limit,
   input  wire logic        charger_input_over_voltage,
   output logic      [3:0]  ldo_enable,
   output logic      [3:0]  ldo_discharge,
   output logic      [23:0] ldo_voltage_select_code,
   output logic      [17:0] buck_voltage_select_code,
   output logic      [7:0]  boost_voltage_select_code,
   output logic             boost_feed_bus_switch,
   output logic             charger_input_bus_switch,
   output logic             irq
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   lotg_pkg::lotg_ldo_ctrl_t ldo_ctrl_reg;
   lotg_pkg::lotg_sw_ctrl_t  sw_ctrl_reg;
   logic [23:0]              ldo_vsel_reg;
   logic [17:0]              buck_vsel_reg;
   logic [7:0]               boost_vsel_reg;
   logic                     vin5_trip_reg;
   logic                     charger_input_trip_reg;
   logic [5:0]               irq_stat_reg;
   logic [5:0]               irq_mask_reg;
   logic [5:0]               query_code_reg;
   logic [3:0]               ldo_bad_s;
   logic [3:0]               ldo_bad_d_reg;
   logic                     vin5_ol_s;
   logic                     charger_input_ol_s;
   logic                     charger_input_ov_s;
   logic                     vin5_fire;
   logic                     charger_input_fire;
   logic                     wr_en;
   logic                     rd_en;
   logic                     addr_ok;
   logic [31:0]              rd_data;
   logic [5:0]               irq_set;

   // ----------------------------------------------------------------
   // decode functions
   // ----------------------------------------------------------------
   function automatic logic mapped(input logic [7:0] a);
      unique case (a)
         lotg_pkg::LDO_CTRL_OFS, lotg_pkg::LDO_STAT_OFS, lotg_pkg::LDO_VSEL_OFS,
         lotg_pkg::BUCK_VSEL_OFS, lotg_pkg::BOOST_VSEL_OFS, lotg_pkg::SW_CTRL_OFS,
         lotg_pkg::SW_STAT_OFS, lotg_pkg::IRQ_STAT_OFS, lotg_pkg::IRQ_MASK_OFS,
         lotg_pkg::VOUT_QUERY_OFS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction : mapped

   // six-bit code to millivolts, shared by buck and ldo
   function automatic logic [15:0] six_bit_mv(input logic [5:0] code);
      logic [15:0] base;
      logic [15:0] step;
      base = 16'h0000;
      step = 16'h0000;
      unique case (code[5:3])
         3'h0: begin base = 16'd600;  step = 16'd25;  end
         3'h1: begin base = 16'd800;  step = 16'd25;  end
         3'h2: begin base = 16'd1000; step = 16'd25;  end
         3'h3: begin base = 16'd1200; step = 16'd50;  end
         3'h4: begin base = 16'd1600; step = 16'd50;  end
         3'h5: begin base = 16'd2000; step = 16'd50;  end
         3'h6: begin base = 16'd2400; step = 16'd100; end
         3'h7: begin base = 16'd3200; step = 16'd100; end
      endcase
      six_bit_mv = 16'(base + step * {13'h0000, code[2:0]});
   endfunction : six_bit_mv

   // boost code to millivolts; top range clamps at 41.4 V
   function automatic logic [15:0] boost_mv(input logic [7:0] code);
      logic [15:0] v;
      v = 16'h0000;
      unique case (code[7:5])
         3'h0, 3'h1: v = 16'd3000;
         3'h2: v = 16'(16'd3000 + 16'd100 * {11'h000, code[4:0]});
         3'h3: v = 16'(16'd6200 + 16'd100 * {11'h000, code[4:0]});
         3'h4: v = 16'(16'd9400 + 16'd100 * {11'h000, code[4:0]});
         3'h5: v = 16'(16'd12600 + 16'd200 * {11'h000, code[4:0]});
         3'h6: v = 16'(16'd19000 + 16'd400 * {11'h000, code[4:0]});
         3'h7: v = (code[4:0] >= 5'h18) ? 16'd41400 :
                   16'(16'd31800 + 16'd400 * {11'h000, code[4:0]});
      endcase
      boost_mv = v;
   endfunction : boost_mv

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   lotg_sync2 #(.W(7)) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .d       ({ldo_below_threshold, vin5_over_limit, charger_input_over_limit,
                 charger_input_over_voltage}),
      .q       ({ldo_bad_s, vin5_ol_s, charger_input_ol_s, charger_input_ov_s})
   );

   lotg_oc_timer u_vin5_timer (
      .clk        (clk),
      .reset_n    (reset_n),
      .over_limit (vin5_ol_s),
      .fire       (vin5_fire)
   );

   lotg_oc_timer u_charger_input_timer (
      .clk        (clk),
      .reset_n    (reset_n),
      .over_limit (charger_input_ol_s),
      .fire       (charger_input_fire)
   );

   // ----------------------------------------------------------------
   // apb slave: zero wait states, error on unmapped address
   // ----------------------------------------------------------------
   assign addr_ok = mapped(paddr);
   assign wr_en   = psel && penable && pwrite && addr_ok;
   assign rd_en   = psel && !penable && !pwrite;

   always_comb begin
      rd_data = 32'h00000000;
      unique case (paddr)
         lotg_pkg::LDO_CTRL_OFS:   rd_data = {20'h00000, ldo_ctrl_reg};
         lotg_pkg::LDO_STAT_OFS:   rd_data = {28'h0000000, ~ldo_bad_s};
         lotg_pkg::LDO_VSEL_OFS:   rd_data = {8'h00, ldo_vsel_reg};
         lotg_pkg::BUCK_VSEL_OFS:  rd_data = {14'h0000, buck_vsel_reg};
         lotg_pkg::BOOST_VSEL_OFS: rd_data = {24'h000000, boost_vsel_reg};
         lotg_pkg::SW_CTRL_OFS:    rd_data = {28'h0000000, sw_ctrl_reg};
         lotg_pkg::SW_STAT_OFS:    rd_data = {26'h0000000, charger_input_ov_s, charger_input_trip_reg,
                                              vin5_trip_reg, charger_input_bus_switch,
                                              boost_feed_bus_switch, 1'b0};
         lotg_pkg::IRQ_STAT_OFS:   rd_data = {26'h0000000, irq_stat_reg};
         lotg_pkg::IRQ_MASK_OFS:   rd_data = {26'h0000000, irq_mask_reg};
         lotg_pkg::VOUT_QUERY_OFS: rd_data = {six_bit_mv(query_code_reg),
                                              boost_mv(boost_vsel_reg)};
         default:                  rd_data = 32'h00000000;
      endcase
   end

   // read data registered in setup so it is stable in the access phase
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         if (rd_en) begin
            prdata <= rd_data;
         end
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ldo_ctrl_reg   <= lotg_pkg::LDO_CTRL_RST;
         ldo_vsel_reg   <= lotg_pkg::LDO_VSEL_RST;
         buck_vsel_reg  <= lotg_pkg::BUCK_VSEL_RST;
         boost_vsel_reg <= lotg_pkg::BOOST_VSEL_RST;
         sw_ctrl_reg    <= lotg_pkg::SW_CTRL_RST;
         irq_mask_reg   <= '0;
         query_code_reg <= '0;
      end else if (wr_en) begin
         unique case (paddr)
            lotg_pkg::LDO_CTRL_OFS:   ldo_ctrl_reg   <= pwdata[11:0];
            lotg_pkg::LDO_VSEL_OFS:   ldo_vsel_reg   <= pwdata[23:0];
            lotg_pkg::BUCK_VSEL_OFS:  buck_vsel_reg  <= pwdata[17:0];
            lotg_pkg::BOOST_VSEL_OFS: boost_vsel_reg <= pwdata[7:0];
            lotg_pkg::SW_CTRL_OFS:    sw_ctrl_reg    <= pwdata[3:0];
            lotg_pkg::IRQ_MASK_OFS:   irq_mask_reg   <= pwdata[5:0];
            lotg_pkg::VOUT_QUERY_OFS: query_code_reg <= pwdata[5:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // ldo, buck and boost outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ldo_enable                <= '0;
         ldo_discharge             <= '0;
         ldo_voltage_select_code   <= lotg_pkg::LDO_VSEL_RST;
         buck_voltage_select_code  <= lotg_pkg::BUCK_VSEL_RST;
         boost_voltage_select_code <= lotg_pkg::BOOST_VSEL_RST;
      end else begin
         ldo_enable                <= ldo_ctrl_reg.enable;
         ldo_discharge             <= ldo_ctrl_reg.discharge & ~ldo_ctrl_reg.enable;
         ldo_voltage_select_code   <= ldo_vsel_reg;
         buck_voltage_select_code  <= buck_vsel_reg;
         boost_voltage_select_code <= boost_vsel_reg;
      end
   end

   // ----------------------------------------------------------------
   // otg switches
   // ----------------------------------------------------------------
   // a trip latches until software writes the enable bit from 0 to 1
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         vin5_trip_reg  <= 1'b0;
         charger_input_trip_reg <= 1'b0;
      end else begin
         if (vin5_fire) begin
            vin5_trip_reg <= 1'b1;
         end else if (wr_en && paddr == lotg_pkg::SW_CTRL_OFS &&
                      pwdata[lotg_pkg::SW_VIN5_EN] && !sw_ctrl_reg.vin5_switch_enable) begin
            vin5_trip_reg <= 1'b0;
         end
         if (charger_input_fire) begin
            charger_input_trip_reg <= 1'b1;
         end else if (wr_en && paddr == lotg_pkg::SW_CTRL_OFS &&
                      pwdata[lotg_pkg::SW_CHARGER_INPUT_EN] && !sw_ctrl_reg.charger_input_switch_enable) begin
            charger_input_trip_reg <= 1'b0;
         end
      end
   end

   // break-before-make: charger_input switch needs the vin5 switch already open
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         boost_feed_bus_switch    <= 1'b0;
         charger_input_bus_switch <= 1'b0;
      end else begin
         boost_feed_bus_switch    <= sw_ctrl_reg.vin5_switch_enable && !vin5_trip_reg &&
                                     !vin5_fire;
         charger_input_bus_switch <= sw_ctrl_reg.charger_input_switch_enable && !charger_input_trip_reg &&
                                     !charger_input_fire && !charger_input_ov_s &&
                                     !boost_feed_bus_switch &&
                                     !(sw_ctrl_reg.vin5_switch_enable &&
                                       !vin5_trip_reg);
      end
   end

   // ----------------------------------------------------------------
   // interrupts: sticky status, write one to clear, set wins
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ldo_bad_d_reg <= '0;
      end else begin
         ldo_bad_d_reg <= ldo_bad_s;
      end
   end

   always_comb begin
      irq_set = {charger_input_fire && sw_ctrl_reg.charger_input_switch_fault_irq_enable,
                 vin5_fire && sw_ctrl_reg.vin5_switch_fault_irq_enable,
                 ldo_bad_s & ~ldo_bad_d_reg & ldo_ctrl_reg.enable &
                 ldo_ctrl_reg.fault_irq_enable};
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_stat_reg <= '0;
      end else if (wr_en && paddr == lotg_pkg::IRQ_STAT_OFS) begin
         irq_stat_reg <= (irq_stat_reg & ~pwdata[5:0]) | irq_set;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_set;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_switch_interlock: assert property (@(posedge clk) disable iff (!reset_n)
      !(boost_feed_bus_switch && charger_input_bus_switch))
      else $error("both otg switches closed");

   a_charger_input_ovp_off: assert property (@(posedge clk) disable iff (!reset_n)
      charger_input_ov_s |=> !charger_input_bus_switch)
      else $error("charger_input switch closed under over-voltage");

   a_vin5_trip_off: assert property (@(posedge clk) disable iff (!reset_n)
      vin5_fire |=> !boost_feed_bus_switch ##1 !boost_feed_bus_switch)
      else $error("vin5 switch still closed after trip");

   a_vin5_stay_off: assert property (@(posedge clk) disable iff (!reset_n)
      (vin5_trip_reg && !wr_en) |=> !boost_feed_bus_switch)
      else $error("vin5 switch reclosed without rearm");

   a_charger_input_trip_off: assert property (@(posedge clk) disable iff (!reset_n)
      charger_input_fire |=> !charger_input_bus_switch)
      else $error("charger_input switch still closed after trip");

   a_charger_input_stay_off: assert property (@(posedge clk) disable iff (!reset_n)
      (charger_input_trip_reg && !wr_en) |=> !charger_input_bus_switch)
      else $error("charger_input switch reclosed without rearm");

   a_vin5_irq_set: assert property (@(posedge clk) disable iff (!reset_n)
      (vin5_fire && sw_ctrl_reg.vin5_switch_fault_irq_enable)
      |=> irq_stat_reg[lotg_pkg::IRQ_VIN5_POS])
      else $error("vin5 fault status not set");

   a_charger_input_irq_set: assert property (@(posedge clk) disable iff (!reset_n)
      (charger_input_fire && sw_ctrl_reg.charger_input_switch_fault_irq_enable)
      |=> irq_stat_reg[lotg_pkg::IRQ_CHARGER_INPUT_POS])
      else $error("charger_input fault status not set");

   a_irq_merge: assert property (@(posedge clk) disable iff (!reset_n)
      |(irq_stat_reg & irq_mask_reg) |=> irq)
      else $error("irq not raised for pending source");

   a_discharge_off: assert property (@(posedge clk) disable iff (!reset_n)
      ldo_discharge != 4'h0 |-> (ldo_discharge & ldo_enable) == 4'h0 ||
      $past(ldo_ctrl_reg.enable) != ldo_enable)
      else $error("discharge on while ldo enabled");

endmodule : lotg_ctrl

// ===== bench/lotg_apb_host.sv
module lotg_apb_host (
   input  wire logic        clk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [7:0]  paddr,
   output logic      [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // called just after a rising edge; holds the request until pready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released data lines show garbage, not the last word
      pwdata <= ~d;
      @(posedge clk);
   endtask : xfer
endmodule : lotg_apb_host

// ===== bench/ldo_and_otg_switch_control_tb_top.sv
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin bad_count++; \
   $display("Error t=%0t got %0h exp %0h", $time, g, x); end end
module ldo_and_otg_switch_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, reset_n = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, irq, e;
   logic [7:0]  paddr, bvs, c8;
   logic [31:0] pwdata, prdata, r, x, y, st = 32'h0000013F;
   logic [3:0]  below, len, ldis;
   logic        v_ol, c_ol, c_ov, sw_v, sw_c;
   logic [23:0] lvs;
   logic [17:0] kvs;
   logic [5:0]  c6;
   int          bad_count = 0, num_checks = 0, cycles = 0;
   localparam int SB [8] = '{600, 800, 1000, 1200, 1600, 2000, 2400, 3200};
   localparam int SS [8] = '{25, 25, 25, 50, 50, 50, 100, 100};
   localparam int BB [8] = '{3000, 3000, 3000, 6200, 9400, 12600, 19000, 31800};
   localparam int BS [8] = '{0, 0, 100, 100, 100, 200, 400, 400};
   always #20 clk = ~clk;
   lotg_apb_host u_lotg_apb_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   lotg_ctrl u_lotg_ctrl (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ldo_below_threshold(below), .vin5_over_limit(v_ol),
      .charger_input_over_limit(c_ol), .charger_input_over_voltage(c_ov), .ldo_enable(len),
      .ldo_discharge(ldis), .ldo_voltage_select_code(lvs), .buck_voltage_select_code(kvs),
      .boost_voltage_select_code(bvs), .boost_feed_bus_switch(sw_v),
      .charger_input_bus_switch(sw_c), .irq(irq));
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         bad_count++;
         stop_test();
      end
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      st ^= st << 13;
      st ^= st >> 17;
      st ^= st << 5;
      return st;
   endfunction : rnd
   function automatic logic [15:0] six_mv(input logic [5:0] c);
      return 16'(SB[c[5:3]] + SS[c[5:3]] * c[2:0]);
   endfunction : six_mv
   function automatic logic [15:0] bst_mv(input logic [7:0] c);
      int v;
      v = BB[c[7:5]] + BS[c[7:5]] * c[4:0];
      return 16'((v > 41400) ? 41400 : v);
   endfunction : bst_mv
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      u_lotg_apb_host.xfer(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      u_lotg_apb_host.xfer(1'b0, a, 32'h0, r, e);
   endtask : rd
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      {below, v_ol, c_ol, c_ov} = 7'h00;
      cyc(10);
      reset_n <= 1'b1;
      cyc(1);
      `CHK({len, ldis, sw_v, sw_c, irq}, 11'h000)
      for (int i = 0; i < 12; i++) begin
         x = rnd() & 32'h00000FFF;
         y = rnd();
         c6 = (i == 0) ? 6'h3F : y[5:0];
         c8 = (i == 0) ? 8'hFF : (i == 1) ? 8'hF8 : (i == 2) ? 8'h3F : y[31:24];
         wr(lotg_pkg::LDO_CTRL_OFS, x);
         rd(lotg_pkg::LDO_CTRL_OFS);
         `CHK(r, x)
         `CHK(len, x[3:0])
         `CHK(ldis, x[7:4] & ~x[3:0])
         wr(lotg_pkg::LDO_VSEL_OFS, y);
         rd(lotg_pkg::LDO_VSEL_OFS);
         `CHK({r, lvs}, {8'h00, y[23:0], y[23:0]})
         wr(lotg_pkg::BUCK_VSEL_OFS, y);
         rd(lotg_pkg::BUCK_VSEL_OFS);
         `CHK({r, kvs}, {14'h0000, y[17:0], y[17:0]})
         wr(lotg_pkg::BOOST_VSEL_OFS, {24'h000000, c8});
         cyc(1);
         `CHK(bvs, c8)
         wr(lotg_pkg::VOUT_QUERY_OFS, {26'h0000000, c6});
         rd(lotg_pkg::VOUT_QUERY_OFS);
         `CHK(r[31:16], six_mv(c6))
         `CHK(r[15:0], bst_mv(c8))
      end
      for (int i = 0; i < 4; i++) begin
         below <= 4'(rnd());
         cyc(4);
         rd(lotg_pkg::LDO_STAT_OFS);
         `CHK(r, {28'h0000000, ~below})
      end
      below <= 4'h0;
      wr(lotg_pkg::LDO_CTRL_OFS, 32'h00000101);
      wr(lotg_pkg::IRQ_STAT_OFS, 32'h0000003F);
      wr(lotg_pkg::IRQ_MASK_OFS, 32'h0000003F);
      `CHK(irq, 1'b0)
      below <= 4'h1;
      cyc(5);
      `CHK(irq, 1'b1)
      rd(lotg_pkg::IRQ_STAT_OFS);
      `CHK(r, 32'h00000001)
      wr(lotg_pkg::IRQ_MASK_OFS, 32'h00000000);
      cyc(2);
      `CHK(irq, 1'b0)
      wr(lotg_pkg::IRQ_MASK_OFS, 32'h0000003F);
      cyc(2);
      `CHK(irq, 1'b1)
      wr(lotg_pkg::IRQ_STAT_OFS, 32'h00000001);
      cyc(2);
      `CHK(irq, 1'b0)
      below <= 4'h0;
      wr(lotg_pkg::LDO_CTRL_OFS, 32'h00000001);
      below <= 4'h1;
      cyc(5);
      rd(lotg_pkg::IRQ_STAT_OFS);
      `CHK({r, irq}, 33'h000000000)
      wr(lotg_pkg::SW_CTRL_OFS, 32'h0000000D);
      cyc(2);
      `CHK({sw_v, sw_c}, 2'b10)
      wr(lotg_pkg::SW_CTRL_OFS, 32'h0000000F);
      cyc(2);
      `CHK({sw_v, sw_c}, 2'b10)
      wr(lotg_pkg::SW_CTRL_OFS, 32'h0000000E);
      cyc(2);
      `CHK({sw_v, sw_c}, 2'b01)
      c_ov <= 1'b1;
      cyc(5);
      `CHK({sw_v, sw_c}, 2'b00)
      c_ov <= 1'b0;
      cyc(5);
      `CHK({sw_v, sw_c}, 2'b01)
      // a burst far shorter than the hold-off must not open the switch
      {v_ol, c_ol} <= 2'b11;
      cyc(100);
      {v_ol, c_ol} <= 2'b00;
      cyc(4);
      `CHK(sw_c, 1'b1)
      wr(lotg_pkg::SW_CTRL_OFS, 32'h0000000C);
      wr(lotg_pkg::SW_CTRL_OFS, 32'h0000000D);
      cyc(2);
      `CHK(sw_v, 1'b1)
      rd(8'h3C);
      `CHK({e, r}, 33'h100000000)
      // the full hold-off lies far beyond the run, so the count itself is watched
      v_ol <= 1'b1;
      cyc(15);
      `CHK(u_lotg_ctrl.u_vin5_timer.count_reg, 23'h00000C)
      v_ol <= 1'b0;
      cyc(4);
      `CHK(u_lotg_ctrl.u_vin5_timer.count_reg, 23'h000000)
      `CHK(sw_v, 1'b1)
      stop_test();
   end
endmodule : ldo_and_otg_switch_control_tb_top
